// >>> design/rss_consts.svh
// register offsets, field positions, opcode patterns and reset values of the rotate/set/sleep core
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

`define RSS_OFS_INSTR       8'h00
`define RSS_OFS_CTRL        8'h04
`define RSS_OFS_STATUS      8'h08
`define RSS_OFS_WREG        8'h0c
`define RSS_OFS_IDXBASE     8'h10
`define RSS_OFS_MADDR       8'h14
`define RSS_OFS_MDATA       8'h18

`define RSS_CTRL_EXT_BIT    0
`define RSS_CTRL_BANK_LSB   8
`define RSS_CTRL_BANK_MSB   11

`define RSS_ST_N_BIT        0
`define RSS_ST_Z_BIT        1
`define RSS_ST_PWRDN_BIT    2
`define RSS_ST_TMOUT_BIT    3
`define RSS_ST_SLEEP_BIT    4

`define RSS_OPC_ROT_MASK    16'hfc00
`define RSS_OPC_ROT_CODE    16'h4000
`define RSS_OPC_FILL_MASK   16'hfe00
`define RSS_OPC_FILL_CODE   16'h6800
`define RSS_OPC_SLEEP       16'h0003
`define RSS_DEST_BIT        9
`define RSS_BANKED_BIT      8

`define RSS_ADDR_W          12
`define RSS_ACCESS_LIMIT    8'h5f
`define RSS_ACCESS_LO_BANK  4'h0
`define RSS_ACCESS_HI_BANK  4'hf
`define RSS_FILL_VALUE      8'hff
`define RSS_FLAG_RST        1'b1
`define RSS_Q_DIV           1

`endif

// >>> design/rss_pkg.sv
// types shared by the rotate/set/sleep core modules
package rss_pkg;
    typedef enum logic [2:0] {RSS_PH_IDLE, RSS_PH_Q1, RSS_PH_Q2, RSS_PH_Q3, RSS_PH_Q4} rss_phase_e;
    typedef enum logic [1:0] {RSS_OP_NOP, RSS_OP_ROT, RSS_OP_FILL, RSS_OP_SLEEP} rss_op_e;
endpackage

// >>> design/rss_core_if.sv
// signals between the core, its phase sequencer and its address resolver
`timescale 1ns/1ps
interface rss_core_if;
    logic                   start;
    logic                   ph_en;
    rss_pkg::rss_phase_e    ph;
    logic [7:0]             f;
    logic                   use_bank;
    logic [3:0]             bank;
    logic                   ext_en;
    logic [11:0]            idx_base;
    logic [11:0]            eff_addr;
    logic                   indexed;

    modport seq      (input start, output ph, ph_en);
    modport agen     (input f, use_bank, bank, ext_en, idx_base, output eff_addr, indexed);
    modport core     (output start, f, use_bank, bank, ext_en, idx_base, input ph, ph_en, eff_addr, indexed);
endinterface

// >>> design/rss_qphase.sv
// four-phase instruction cycle sequencer with phase-rate divider
`timescale 1ns/1ps
module rss_qphase #(
    parameter int Q_DIV = 1
) (
    input  wire logic   clk,
    input  wire logic   rst_b,
    rss_core_if.seq     cif
);
    localparam int CW = (Q_DIV > 1) ? $clog2(Q_DIV) : 1;
    localparam logic [CW-1:0] CNT_LAST = CW'(Q_DIV - 1);

    generate
        if (Q_DIV < 1) begin : g_bad_div
            $error("Q_DIV must be at least 1");
        end
    endgenerate

    logic [CW-1:0]          cnt;
    logic [CW-1:0]          next_cnt;
    rss_pkg::rss_phase_e    ph;
    rss_pkg::rss_phase_e    next_ph;
    logic                   tick;

    assign tick      = (cnt == CNT_LAST);
    assign cif.ph    = ph;
    assign cif.ph_en = tick && (ph != rss_pkg::RSS_PH_IDLE);

    always_comb begin
        next_cnt = (ph == rss_pkg::RSS_PH_IDLE || tick) ? '0 : cnt + CW'(1);
        next_ph  = ph;
        case (ph)
            rss_pkg::RSS_PH_IDLE: if (cif.start) next_ph = rss_pkg::RSS_PH_Q1;  // [RULE_10]
            rss_pkg::RSS_PH_Q1:   if (tick) next_ph = rss_pkg::RSS_PH_Q2;
            rss_pkg::RSS_PH_Q2:   if (tick) next_ph = rss_pkg::RSS_PH_Q3;
            rss_pkg::RSS_PH_Q3:   if (tick) next_ph = rss_pkg::RSS_PH_Q4;
            rss_pkg::RSS_PH_Q4:   if (tick) next_ph = rss_pkg::RSS_PH_IDLE;
            default:              next_ph = rss_pkg::RSS_PH_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
            ph  <= rss_pkg::RSS_PH_IDLE;
        end else begin
            cnt <= next_cnt;
            ph  <= next_ph;
        end
    end

    AST_PHASE_ORDER: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_10]
        (cif.ph_en && ph != rss_pkg::RSS_PH_Q4) |=> (ph == rss_pkg::rss_phase_e'($past(ph) + 3'h1)))
        else $error("phase did not advance to the next quarter");
endmodule // rss_qphase

// >>> design/rss_agen.sv
// operand address resolver: access bank, banked and indexed literal offset
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_agen (
    rss_core_if.agen    cif
);
    always_comb begin
        cif.indexed = !cif.use_bank && cif.ext_en && (cif.f <= `RSS_ACCESS_LIMIT);  // [RULE_04]
        if (cif.indexed) begin
            cif.eff_addr = cif.idx_base + {4'h0, cif.f};  // [RULE_04]
        end else if (cif.use_bank) begin
            cif.eff_addr = {cif.bank, cif.f};  // [RULE_03]
        end else if (cif.f <= `RSS_ACCESS_LIMIT) begin
            cif.eff_addr = {`RSS_ACCESS_LO_BANK, cif.f};  // [RULE_03]
        end else begin
            cif.eff_addr = {`RSS_ACCESS_HI_BANK, cif.f};  // [RULE_03]
        end
    end
endmodule // rss_agen

// >>> design/rss_exec.sv
// rotate-right, fill-ones and sleep execution core with Avalon-MM register slave
`timescale 1ns/1ps
`include "rss_consts.svh"
// Operation
// (RULE_01) rotate opcode shifts byte right, bit 0 into bit 7, updates only N and Z
// (RULE_02) rotate result goes to accumulator when destination bit 0, file byte when 1
// (RULE_03) access bit 0 selects access bank; 1 lets the bank register choose
// (RULE_04) extended set, access bit 0, address up to 5Fh: indexed literal offset
// (RULE_05) fill opcode writes FFh to the addressed byte, flags untouched
// (RULE_06) sleep clears power-down flag and sets time-out flag, both active low
// (RULE_07) sleep clears the watchdog counter and its postscaler
// (RULE_08) after sleep the core halts; nothing executes until a wake-up
// (RULE_09) watchdog expiry waking the core clears the time-out flag
// (RULE_10) each instruction is one word, one cycle of four phases
module rss_exec #(
    parameter int Q_DIV = `RSS_Q_DIV
) (
    input  wire logic           clk,
    input  wire logic           rst_b,
    input  wire logic [7:0]     avs_address,
    input  wire logic           avs_read,
    input  wire logic           avs_write,
    input  wire logic [31:0]    avs_writedata,
    input  wire logic [3:0]     avs_byteenable,
    output logic      [31:0]    avs_readdata,
    output logic                avs_waitrequest,
    input  wire logic           watchdog_expired,
    input  wire logic           wake_event,
    output logic                sleep_active,
    output logic                watchdog_clear
);
    localparam int MEM_BYTES = 1 << `RSS_ADDR_W;

    rss_core_if cif();

    rss_qphase #(
        .Q_DIV  (Q_DIV)
    ) u_qphase (
        .clk    (clk),
        .rst_b  (rst_b),
        .cif    (cif)
    );

    rss_agen u_agen (
        .cif    (cif)
    );

    function automatic rss_pkg::rss_op_e decode_op(input logic [15:0] w);
        if ((w & `RSS_OPC_ROT_MASK) == `RSS_OPC_ROT_CODE) begin
            return rss_pkg::RSS_OP_ROT;
        end else if ((w & `RSS_OPC_FILL_MASK) == `RSS_OPC_FILL_CODE) begin
            return rss_pkg::RSS_OP_FILL;
        end else if (w == `RSS_OPC_SLEEP) begin
            return rss_pkg::RSS_OP_SLEEP;
        end
        return rss_pkg::RSS_OP_NOP;
    endfunction

    function automatic logic [7:0] rot_right(input logic [7:0] b);
        return {b[0], b[7:1]};
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction

    logic [7:0]             mem [0:MEM_BYTES-1];
    logic                   mem_we;
    logic [11:0]            mem_wa;
    logic [7:0]             mem_wd;

    logic                   wait_q;
    logic                   next_wait;
    logic [31:0]            rdata;
    logic [31:0]            next_rdata;
    logic [15:0]            ins_q;
    logic [15:0]            next_ins;
    logic                   start_q;
    logic                   next_start;
    logic [7:0]             wreg;
    logic [7:0]             next_wreg;
    logic [7:0]             opnd_q;
    logic [7:0]             next_opnd;
    logic [7:0]             res_q;
    logic [7:0]             next_res;
    logic [11:0]            eff_q;
    logic [11:0]            next_eff;
    logic                   flag_n;
    logic                   next_flag_n;
    logic                   flag_z;
    logic                   next_flag_z;
    logic                   power_down_flag;
    logic                   next_power_down_flag;
    logic                   timeout_flag;
    logic                   next_timeout_flag;
    logic                   sleeping;
    logic                   next_sleeping;
    logic                   watchdog_clr;
    logic                   next_watchdog_clr;
    logic                   ext_en;
    logic                   next_ext_en;
    logic [3:0]             bank_select_reg;
    logic [3:0]             next_bank_select_reg;
    logic [11:0]            idx_base;
    logic [11:0]            next_idx_base;
    logic [11:0]            mem_addr;
    logic [11:0]            next_mem_addr;

    rss_pkg::rss_op_e       op;
    logic                   busy;
    logic                   acc_ok;
    logic                   take;
    logic                   end_q1;
    logic                   end_q2;
    logic                   end_q3;
    logic                   end_q4;
    logic [31:0]            cur_val;
    logic [31:0]            wr_val;

    assign cif.start    = start_q;
    assign cif.f        = ins_q[7:0];
    assign cif.use_bank = ins_q[`RSS_BANKED_BIT];
    assign cif.bank     = bank_select_reg;
    assign cif.ext_en   = ext_en;
    assign cif.idx_base = idx_base;

    assign op     = decode_op(ins_q);
    assign end_q1 = cif.ph_en && cif.ph == rss_pkg::RSS_PH_Q1;
    assign end_q2 = cif.ph_en && cif.ph == rss_pkg::RSS_PH_Q2;
    assign end_q3 = cif.ph_en && cif.ph == rss_pkg::RSS_PH_Q3;
    assign end_q4 = cif.ph_en && cif.ph == rss_pkg::RSS_PH_Q4;
    // bus stalls while an instruction is in flight, so bus and core never both touch memory
    assign busy   = start_q || (cif.ph != rss_pkg::RSS_PH_IDLE);
    assign acc_ok = (avs_read || avs_write) && wait_q && !busy;
    assign take   = (avs_read || avs_write) && !wait_q;

    always_comb begin
        case (avs_address)
            `RSS_OFS_INSTR:   cur_val = {16'h0000, ins_q};
            `RSS_OFS_CTRL:    cur_val = {20'h00000, bank_select_reg, 7'h00, ext_en};
            `RSS_OFS_STATUS:  cur_val = {27'h0000000, sleeping, timeout_flag, power_down_flag, flag_z, flag_n};
            `RSS_OFS_WREG:    cur_val = {24'h000000, wreg};
            `RSS_OFS_IDXBASE: cur_val = {20'h00000, idx_base};
            `RSS_OFS_MADDR:   cur_val = {20'h00000, mem_addr};
            `RSS_OFS_MDATA:   cur_val = {24'h000000, mem[mem_addr]};
            default:          cur_val = 32'h00000000;
        endcase
        wr_val = merge_be(cur_val, avs_writedata, avs_byteenable);
    end

    always_comb begin
        next_wait            = !acc_ok;
        next_rdata           = rdata;
        next_ins             = ins_q;
        next_start           = 1'b0;
        next_wreg            = wreg;
        next_opnd            = opnd_q;
        next_res             = res_q;
        next_eff             = eff_q;
        next_flag_n          = flag_n;
        next_flag_z          = flag_z;
        next_power_down_flag = power_down_flag;
        next_timeout_flag    = timeout_flag;
        next_sleeping        = sleeping;
        next_watchdog_clr    = 1'b0;
        next_ext_en          = ext_en;
        next_bank_select_reg = bank_select_reg;
        next_idx_base        = idx_base;
        next_mem_addr        = mem_addr;
        mem_we               = 1'b0;
        mem_wa               = mem_addr;
        mem_wd               = wr_val[7:0];

        if (acc_ok && avs_read) next_rdata = cur_val;
        if (take && avs_write) begin
            case (avs_address)
                `RSS_OFS_INSTR: begin
                    // a word written while asleep is dropped
                    if (!sleeping) begin  // [RULE_08]
                        next_ins   = wr_val[15:0];
                        next_start = 1'b1;
                    end
                end
                `RSS_OFS_CTRL: begin
                    next_ext_en          = wr_val[`RSS_CTRL_EXT_BIT];
                    next_bank_select_reg = wr_val[`RSS_CTRL_BANK_MSB:`RSS_CTRL_BANK_LSB];
                end
                `RSS_OFS_WREG:    next_wreg     = wr_val[7:0];
                `RSS_OFS_IDXBASE: next_idx_base = wr_val[11:0];
                `RSS_OFS_MADDR:   next_mem_addr = wr_val[11:0];
                `RSS_OFS_MDATA:   mem_we        = 1'b1;
                default: ;
            endcase
        end

        if (end_q1) next_eff = cif.eff_addr;  // [RULE_03] [RULE_04]
        if (end_q2 && (op == rss_pkg::RSS_OP_ROT || op == rss_pkg::RSS_OP_FILL)) begin
            next_opnd = mem[eff_q];
        end
        if (end_q3) begin
            next_res = (op == rss_pkg::RSS_OP_FILL) ? `RSS_FILL_VALUE : rot_right(opnd_q);  // [RULE_01] [RULE_05]
        end
        if (end_q4) begin
            case (op)
                rss_pkg::RSS_OP_ROT: begin
                    if (ins_q[`RSS_DEST_BIT]) begin  // [RULE_02]
                        mem_we = 1'b1;
                        mem_wa = eff_q;
                        mem_wd = res_q;
                    end else begin
                        next_wreg = res_q;  // [RULE_02]
                    end
                    next_flag_n = res_q[7];  // [RULE_01]
                    next_flag_z = (res_q == 8'h00);  // [RULE_01]
                end
                rss_pkg::RSS_OP_FILL: begin
                    mem_we = 1'b1;  // [RULE_05]
                    mem_wa = eff_q;
                    mem_wd = res_q;
                end
                rss_pkg::RSS_OP_SLEEP: begin
                    next_power_down_flag = 1'b0;  // [RULE_06]
                    next_timeout_flag    = 1'b1;  // [RULE_06]
                    next_watchdog_clr    = 1'b1;  // [RULE_07]
                    next_sleeping        = 1'b1;  // [RULE_08]
                end
                default: ;
            endcase
        end

        // watchdog wins over a simultaneous other wake so the cause is recorded
        if (sleeping) begin
            if (watchdog_expired) begin
                next_timeout_flag = 1'b0;  // [RULE_09]
                next_sleeping     = 1'b0;
            end else if (wake_event) begin
                next_sleeping = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q          <= 1'b1;
            rdata           <= 32'h00000000;
            ins_q           <= 16'h0000;
            start_q         <= 1'b0;
            wreg            <= 8'h00;
            opnd_q          <= 8'h00;
            res_q           <= 8'h00;
            eff_q           <= 12'h000;
            flag_n          <= 1'b0;
            flag_z          <= 1'b0;
            power_down_flag <= `RSS_FLAG_RST;
            timeout_flag    <= `RSS_FLAG_RST;
            sleeping        <= 1'b0;
            watchdog_clr    <= 1'b0;
            ext_en          <= 1'b0;
            bank_select_reg <= 4'h0;
            idx_base        <= 12'h000;
            mem_addr        <= 12'h000;
        end else begin
            wait_q          <= next_wait;
            rdata           <= next_rdata;
            ins_q           <= next_ins;
            start_q         <= next_start;
            wreg            <= next_wreg;
            opnd_q          <= next_opnd;
            res_q           <= next_res;
            eff_q           <= next_eff;
            flag_n          <= next_flag_n;
            flag_z          <= next_flag_z;
            power_down_flag <= next_power_down_flag;
            timeout_flag    <= next_timeout_flag;
            sleeping        <= next_sleeping;
            watchdog_clr    <= next_watchdog_clr;
            ext_en          <= next_ext_en;
            bank_select_reg <= next_bank_select_reg;
            idx_base        <= next_idx_base;
            mem_addr        <= next_mem_addr;
        end
    end

    // memory content is not reset; software must initialise it
    always_ff @(posedge clk) begin
        if (mem_we) mem[mem_wa] <= mem_wd;
    end

    assign avs_readdata    = rdata;
    assign avs_waitrequest = wait_q;
    assign sleep_active    = sleeping;
    assign watchdog_clear  = watchdog_clr;

    AST_ROT_TO_FILE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
        (end_q4 && op == rss_pkg::RSS_OP_ROT && ins_q[`RSS_DEST_BIT])
        |=> (mem[eff_q] == {opnd_q[0], opnd_q[7:1]}))
        else $error("rotated byte not written back to file");
    AST_ROT_TO_W: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_02]
        (end_q4 && op == rss_pkg::RSS_OP_ROT && !ins_q[`RSS_DEST_BIT])
        |=> (wreg == {opnd_q[0], opnd_q[7:1]} && mem[eff_q] == opnd_q))
        else $error("rotate with destination 0 did not land in accumulator only");
    AST_ROT_FLAGS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
        (end_q4 && op == rss_pkg::RSS_OP_ROT)
        |=> (flag_n == opnd_q[0] && flag_z == (opnd_q == 8'h00) && $stable(timeout_flag) && $stable(power_down_flag)))
        else $error("rotate flags wrong");
    AST_BANKED_ADDR: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
        (end_q1 && ins_q[`RSS_BANKED_BIT]) |=> (eff_q == {bank_select_reg, ins_q[7:0]}))
        else $error("banked operand address wrong");
    AST_ACCESS_ADDR: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
        (end_q1 && !ins_q[`RSS_BANKED_BIT] && !(ext_en && ins_q[7:0] <= `RSS_ACCESS_LIMIT))
        |=> (eff_q[7:0] == ins_q[7:0] && !cif.indexed
             && eff_q[11:8] == ((ins_q[7:0] > `RSS_ACCESS_LIMIT) ? `RSS_ACCESS_HI_BANK : `RSS_ACCESS_LO_BANK)))
        else $error("access bank address wrong");
    AST_INDEXED_ADDR: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_04]
        (end_q1 && !ins_q[`RSS_BANKED_BIT] && ext_en && ins_q[7:0] <= `RSS_ACCESS_LIMIT)
        |=> (eff_q == idx_base + {4'h0, ins_q[7:0]} && cif.indexed))
        else $error("indexed literal offset address wrong");
    AST_FILL_ONES: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_05]
        (end_q4 && op == rss_pkg::RSS_OP_FILL)
        |=> (mem[eff_q] == `RSS_FILL_VALUE && $stable(flag_n) && $stable(flag_z) && $stable(wreg)))
        else $error("fill did not write ones or disturbed flags");
    AST_SLEEP_FLAGS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
        (end_q4 && op == rss_pkg::RSS_OP_SLEEP) |=> (!power_down_flag && timeout_flag && sleeping))
        else $error("sleep flag update wrong");
    AST_WATCHDOG_CLEAR: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_07]
        watchdog_clear |-> ($past(end_q4) && $past(op) == rss_pkg::RSS_OP_SLEEP ##1 !watchdog_clear))
        else $error("watchdog clear pulse without sleep or too long");
    AST_ASLEEP_IDLE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_08]
        (sleeping && !watchdog_expired && !wake_event) |=> (sleeping && cif.ph == rss_pkg::RSS_PH_IDLE && !start_q))
        else $error("core ran while asleep");
    AST_WATCHDOG_WAKE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_09]
        (sleeping && watchdog_expired) |=> (!timeout_flag && !sleeping))
        else $error("watchdog wake did not record time-out");
    AST_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_10]
        ($rose(start_q) && Q_DIV == 1) |=> (cif.ph == rss_pkg::RSS_PH_Q1) ##4 (cif.ph == rss_pkg::RSS_PH_IDLE))
        else $error("instruction did not take four phases");
endmodule // rss_exec

// >>> tb/rotate_set_sleep_exec_test.sv
// self-checking bench for the rotate/set/sleep core, driven over its register bus
`timescale 1ns/1ps
`include "rss_consts.svh"
module rotate_set_sleep_exec_test;
    logic           clk = 1'b0;
    logic           rst_b;
    logic [7:0]     avs_address;
    logic           avs_read;
    logic           avs_write;
    logic [31:0]    avs_writedata;
    logic [3:0]     avs_byteenable;
    logic [31:0]    avs_readdata;
    logic           avs_waitrequest;
    logic           watchdog_expired;
    logic           wake_event;
    logic           sleep_active;
    logic           watchdog_clear;
    int             n_errors;
    int             comparisons;
    int             n_clr = 0;
    int             clr0;

    rss_exec #(.Q_DIV(1)) uut (
        .clk             (clk),
        .rst_b           (rst_b),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .watchdog_expired (watchdog_expired),
        .wake_event      (wake_event),
        .sleep_active    (sleep_active),
        .watchdog_clear  (watchdog_clear)
    );

    always #50 clk = ~clk;

    // one pulse per sleep is expected, so count every high cycle
    always @(posedge clk) begin
        if (watchdog_clear === 1'b1) begin
            n_clr <= n_clr + 1;
        end
    end

    task automatic end_of_test;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // holds the request until waitrequest is seen low at a rising edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int i;
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        if (i == 200) begin
            n_errors++;
            end_of_test;
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0000_0000, q);
        chk(q, e);
    endtask

    task automatic mem(input logic [11:0] a, input logic [7:0] v);
        wr(`RSS_OFS_MADDR, {20'h0_0000, a});
        wr(`RSS_OFS_MDATA, {24'h00_0000, v});
    endtask

    task automatic mchk(input logic [11:0] a, input logic [7:0] v);
        wr(`RSS_OFS_MADDR, {20'h0_0000, a});
        rchk(`RSS_OFS_MDATA, {24'h00_0000, v});
    endtask

    initial begin
        rst_b = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        watchdog_expired = 1'b0;
        wake_event = 1'b0;
        n_errors = 0;
        comparisons = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rchk(`RSS_OFS_STATUS, 32'h0000_000c);
        rchk(8'h1c, 32'h0000_0000);
        mem(12'h010, 8'hd7);
        wr(`RSS_OFS_INSTR, 32'h0000_4210);
        rchk(`RSS_OFS_STATUS, 32'h0000_000d);
        mchk(12'h010, 8'heb);
        wr(`RSS_OFS_INSTR, 32'h0000_4010);
        rchk(`RSS_OFS_WREG, 32'h0000_00f5);
        mchk(12'h010, 8'heb);
        mem(12'h011, 8'h00);
        wr(`RSS_OFS_INSTR, 32'h0000_4211);
        rchk(`RSS_OFS_STATUS, 32'h0000_000e);
        // bank 3 selected, then both access kinds of fill
        wr(`RSS_OFS_CTRL, 32'h0000_0300);
        mem(12'h320, 8'h5a);
        wr(`RSS_OFS_INSTR, 32'h0000_6920);
        mchk(12'h320, 8'hff);
        rchk(`RSS_OFS_STATUS, 32'h0000_000e);
        mem(12'hf80, 8'h00);
        wr(`RSS_OFS_INSTR, 32'h0000_6880);
        mchk(12'hf80, 8'hff);
        // indexed offset only up to 5fh; 60h falls back to the access bank
        wr(`RSS_OFS_CTRL, 32'h0000_0001);
        wr(`RSS_OFS_IDXBASE, 32'h0000_0200);
        mem(12'h25f, 8'h00);
        mem(12'h05f, 8'h00);
        wr(`RSS_OFS_INSTR, 32'h0000_685f);
        mchk(12'h25f, 8'hff);
        mchk(12'h05f, 8'h00);
        mem(12'hf60, 8'h02);
        wr(`RSS_OFS_INSTR, 32'h0000_4260);
        mchk(12'hf60, 8'h01);
        // only the bank lane is enabled, so the extended-set bit must survive
        avs_byteenable <= 4'h2;
        wr(`RSS_OFS_CTRL, 32'h0000_0a00);
        avs_byteenable <= 4'hf;
        rchk(`RSS_OFS_CTRL, 32'h0000_0a01);
        // sleep, a dropped instruction, then a watchdog wake
        clr0 = n_clr;
        wr(`RSS_OFS_INSTR, 32'h0000_0003);
        rchk(`RSS_OFS_STATUS, 32'h0000_0018);
        chk({31'h0, sleep_active}, 32'h0000_0001);
        chk(n_clr - clr0, 32'h0000_0001);
        mem(12'h030, 8'h00);
        wr(`RSS_OFS_INSTR, 32'h0000_6830);
        mchk(12'h030, 8'h00);
        watchdog_expired <= 1'b1;
        @(posedge clk);
        watchdog_expired <= 1'b0;
        repeat (2) @(posedge clk);
        rchk(`RSS_OFS_STATUS, 32'h0000_0000);
        // other wake source keeps the time-out flag set
        clr0 = n_clr;
        wr(`RSS_OFS_INSTR, 32'h0000_0003);
        rchk(`RSS_OFS_STATUS, 32'h0000_0018);
        chk(n_clr - clr0, 32'h0000_0001);
        wake_event <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
        repeat (2) @(posedge clk);
        rchk(`RSS_OFS_STATUS, 32'h0000_0008);
        end_of_test;
    end
endmodule // rotate_set_sleep_exec_test
